// >>> logic/uspsr_ctrl.sv
// suspend/resume controller top: APB registers, suspend flags, wakeup interrupts
`timescale 1ns/100ps
`default_nettype none
module uspsr_ctrl
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link side status from the transceiver
   input wire logic [1:0] lineStateIn,
   input wire logic hostResumeIn,
   input wire logic remoteWakeIn,
   input wire logic hsLevelIn,
   // transceiver control
   output logic lineDriveEn,
   output logic [1:0] lineDriveState,
   output logic [1:0] ctrlLineState,
   output logic hsMode,
   output logic sofEnable,
   output logic lowPowerOut,
   output logic [7:0] powerDownOut,
   output logic clockGateOut,
   output logic discDetectOut,
   // interrupt
   output logic irq
);
   // ****************************************
   // input synchronisers
   // ****************************************
   logic [5:0] syncA_ff;
   logic [5:0] syncB_ff;
   logic hostResumePrev_ff;
   logic remoteWakePrev_ff;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syncA_ff <= 6'h00;
         syncB_ff <= 6'h00;
         hostResumePrev_ff <= 1'b0;
         remoteWakePrev_ff <= 1'b0;
      end
      else
      begin
         syncA_ff <= {hsLevelIn, remoteWakeIn, hostResumeIn, lineStateIn, 1'b0};
         syncB_ff <= syncA_ff;
         hostResumePrev_ff <= syncB_ff[3];
         remoteWakePrev_ff <= syncB_ff[4];
      end
   end
   logic [1:0] lineSync;
   logic hsLevelSync;
   logic hostResumeRise;
   logic remoteWakeRise;
   assign lineSync = syncB_ff[2:1];
   assign hsLevelSync = syncB_ff[5];
   assign hostResumeRise = syncB_ff[3] && !hostResumePrev_ff;
   assign remoteWakeRise = syncB_ff[4] && !remoteWakePrev_ff;

   // ****************************************
   // registers
   // ****************************************
   logic hostRole_ff;
   logic run_ff;
   logic portSuspend_ff;
   logic lowPower_ff;
   logic forceResume_ff;
   logic discEn_ff;
   logic clkGate_ff;
   logic [uspsr_pkg::PWD_W-1:0] pwd_ff;
   logic [uspsr_pkg::IRQ_W-1:0] irqStatus_ff;
   logic [uspsr_pkg::IRQ_W-1:0] irqMask_ff;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic wrAcc;
   logic rdAcc;
   assign wrAcc = psel && penable && pwrite;
   assign rdAcc = psel && penable && !pwrite;

   logic mapped;
   assign mapped = hit(paddr, uspsr_pkg::PORT_STATUS_CONTROL_REG)
      || hit(paddr, uspsr_pkg::PHY_CONTROL_REG) || hit(paddr, uspsr_pkg::PHY_POWER_DOWN_REG)
      || hit(paddr, uspsr_pkg::IRQ_STATUS_REG) || hit(paddr, uspsr_pkg::IRQ_MASK_REG)
      || hit(paddr, uspsr_pkg::LINE_STATE_REG);

   logic wrPsc;
   logic wrPcr;
   logic wrPwd;
   assign wrPsc = wrAcc && hit(paddr, uspsr_pkg::PORT_STATUS_CONTROL_REG);
   assign wrPcr = wrAcc && hit(paddr, uspsr_pkg::PHY_CONTROL_REG);
   assign wrPwd = wrAcc && hit(paddr, uspsr_pkg::PHY_POWER_DOWN_REG);

   // resume sequencer hookup
   uspsr_pkg::uspsr_drive_t seqDrive;
   uspsr_pkg::uspsr_seq_evt_t seqEvt;
   logic seqBypass;
   logic seqHs;
   logic seqSof;
   logic seqBusy;
   logic seqStart;

   // wakeup classification
   logic wakeInSuspend;
   logic wakeInLowPower;
   assign wakeInSuspend = remoteWakeRise && portSuspend_ff && !lowPower_ff;
   assign wakeInLowPower = remoteWakeRise && lowPower_ff && (pwd_ff == uspsr_pkg::PWD_NONE)
      && !clkGate_ff;
   logic anyWake;
   assign anyWake = remoteWakeRise && (portSuspend_ff || lowPower_ff);

   // host resume starts on a remote wake or a software resume of a suspended port
   assign seqStart = hostRole_ff && !seqBusy && portSuspend_ff
      && (anyWake || (wrPsc && pwdata[uspsr_pkg::PSC_FORCE_RESUME]));

   // ****************************************
   // port status control
   // ****************************************
   logic allowLowPower;
   assign allowLowPower = hostRole_ff ? 1'b1 : (!run_ff || portSuspend_ff);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hostRole_ff <= 1'b0;
         run_ff <= 1'b0;
         forceResume_ff <= 1'b0;
      end
      else
      begin
         forceResume_ff <= 1'b0;
         if (wrPsc)
         begin
            hostRole_ff <= pwdata[uspsr_pkg::PSC_HOST_ROLE];
            run_ff <= pwdata[uspsr_pkg::PSC_RUN];
            forceResume_ff <= pwdata[uspsr_pkg::PSC_FORCE_RESUME] && !hostRole_ff
               && !lowPower_ff;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         portSuspend_ff <= 1'b0;
      else if (seqStart || (!hostRole_ff && (hostResumeRise || forceResume_ff)))
         portSuspend_ff <= 1'b0;
      else if (wrPsc)
         portSuspend_ff <= pwdata[uspsr_pkg::PSC_PORT_SUSPEND];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         lowPower_ff <= 1'b0;
      else if (!hostRole_ff && hostResumeRise)
         lowPower_ff <= 1'b0;
      else if ((remoteWakeRise && lowPower_ff) || seqStart)
         lowPower_ff <= 1'b0;
      else if (wrPsc)
         lowPower_ff <= pwdata[uspsr_pkg::PSC_LOW_POWER] && allowLowPower;
   end

   // ****************************************
   // phy control and power down
   // ****************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         discEn_ff <= 1'b0;
         clkGate_ff <= 1'b0;
      end
      else if (anyWake || (!hostRole_ff && hostResumeRise))
         clkGate_ff <= 1'b0;
      else if (wrPcr)
      begin
         discEn_ff <= pwdata[uspsr_pkg::PCR_DISC_EN];
         clkGate_ff <= pwdata[uspsr_pkg::PCR_CLK_GATE];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pwd_ff <= uspsr_pkg::PWD_NONE;
      else if (anyWake || (!hostRole_ff && hostResumeRise))
         pwd_ff <= uspsr_pkg::PWD_NONE;
      else if (wrPwd)
         pwd_ff <= pwdata[uspsr_pkg::PWD_W-1:0];
   end

   // ****************************************
   // interrupts
   // ****************************************
   logic [uspsr_pkg::IRQ_W-1:0] irqSet;
   always_comb
   begin
      irqSet = '0;
      irqSet[uspsr_pkg::IRQ_PORT_CHANGE] = wakeInSuspend || hostResumeRise;
      irqSet[uspsr_pkg::IRQ_REMOTE_WAKE] = wakeInLowPower;
      irqSet[uspsr_pkg::IRQ_HS_DISCONNECT] = seqEvt.hsDisconnect;
      irqSet[uspsr_pkg::IRQ_RESUME_DONE] = seqEvt.resumeDone;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irqStatus_ff <= '0;
      else if (wrAcc && hit(paddr, uspsr_pkg::IRQ_STATUS_REG))
         irqStatus_ff <= (irqStatus_ff & ~pwdata[uspsr_pkg::IRQ_W-1:0]) | irqSet;
      else
         irqStatus_ff <= irqStatus_ff | irqSet;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irqMask_ff <= '0;
      else if (wrAcc && hit(paddr, uspsr_pkg::IRQ_MASK_REG))
         irqMask_ff <= pwdata[uspsr_pkg::IRQ_W-1:0];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |((irqStatus_ff | irqSet) & irqMask_ff);
   end

   // ****************************************
   // apb read path
   // ****************************************
   logic [31:0] rdMux;
   always_comb
   begin
      rdMux = uspsr_pkg::RD_ZERO;
      unique case (1'b1)
         hit(paddr, uspsr_pkg::PORT_STATUS_CONTROL_REG):
         begin
            rdMux[uspsr_pkg::PSC_HOST_ROLE] = hostRole_ff;
            rdMux[uspsr_pkg::PSC_RUN] = run_ff;
            rdMux[uspsr_pkg::PSC_PORT_SUSPEND] = portSuspend_ff;
            rdMux[uspsr_pkg::PSC_LOW_POWER] = lowPower_ff;
            rdMux[uspsr_pkg::PSC_HIGH_SPEED] = seqHs;
         end
         hit(paddr, uspsr_pkg::PHY_CONTROL_REG):
         begin
            rdMux[uspsr_pkg::PCR_DISC_EN] = discEn_ff;
            rdMux[uspsr_pkg::PCR_CLK_GATE] = clkGate_ff;
         end
         hit(paddr, uspsr_pkg::PHY_POWER_DOWN_REG):
            rdMux[uspsr_pkg::PWD_W-1:0] = pwd_ff;
         hit(paddr, uspsr_pkg::IRQ_STATUS_REG):
            rdMux[uspsr_pkg::IRQ_W-1:0] = irqStatus_ff;
         hit(paddr, uspsr_pkg::IRQ_MASK_REG):
            rdMux[uspsr_pkg::IRQ_W-1:0] = irqMask_ff;
         hit(paddr, uspsr_pkg::LINE_STATE_REG):
            rdMux[1:0] = lineSync;
         default:
            rdMux = uspsr_pkg::RD_ZERO;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= uspsr_pkg::RD_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (psel && !penable && !pwrite)
            prdata <= rdMux;
      end
   end

   // ****************************************
   // resume sequencer and transceiver outputs
   // ****************************************
   uspsr_resume_seq u_seq
   (
      .clk(clk),
      .rst_n(rst_n),
      .start(seqStart),
      .discEnable(discEn_ff),
      .hsLevelSeen(hsLevelSync),
      .lineDrive(seqDrive),
      .bypass(seqBypass),
      .hsSwitch(seqHs),
      .sofAllow(seqSof),
      .busy(seqBusy),
      .evt(seqEvt)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lineDriveEn <= 1'b0;
         lineDriveState <= 2'h0;
         ctrlLineState <= 2'h0;
         hsMode <= 1'b0;
         sofEnable <= 1'b0;
         lowPowerOut <= 1'b0;
         powerDownOut <= uspsr_pkg::PWD_NONE;
         clockGateOut <= 1'b0;
         discDetectOut <= 1'b0;
      end
      else
      begin
         lineDriveEn <= seqDrive.drive;
         lineDriveState <= seqDrive.state;
         ctrlLineState <= seqBypass ? lineSync : uspsr_pkg::LS_SE0;
         hsMode <= seqHs;
         sofEnable <= seqSof;
         lowPowerOut <= lowPower_ff;
         powerDownOut <= pwd_ff;
         clockGateOut <= clkGate_ff;
         discDetectOut <= discEn_ff;
      end
   end

   logic unusedRd;
   assign unusedRd = rdAcc ^ syncB_ff[0] ^ (|pwdata[31:8]) ^ (&pwd_ff);
endmodule
`default_nettype wire

// >>> logic/uspsr_resume_seq.sv
// host resume sequencer: K drive, SE0 end, speed handover, idle before frames
`timescale 1ns/100ps
`default_nettype none
module uspsr_resume_seq
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic discEnable,
   input wire logic hsLevelSeen,
   // line and controller side
   output uspsr_pkg::uspsr_drive_t lineDrive,
   output logic bypass,
   output logic hsSwitch,
   output logic sofAllow,
   output logic busy,
   output uspsr_pkg::uspsr_seq_evt_t evt
);
   typedef enum logic [2:0] {S_IDLE, S_K, S_SE0, S_HS, S_WAIT, S_RUN} uspsr_seq_st_t;
   uspsr_seq_st_t state_ff;
   logic [uspsr_pkg::CNT_W-1:0] cnt_ff;
   localparam logic [uspsr_pkg::CNT_W-1:0] K_LAST = uspsr_pkg::CNT_W'(uspsr_pkg::RESUME_K_CYC - 1);
   localparam logic [uspsr_pkg::CNT_W-1:0] IDLE_LAST = uspsr_pkg::CNT_W'(uspsr_pkg::SE0_IDLE_CYC - 1);
   localparam logic [uspsr_pkg::CNT_W-1:0] CNT_ZERO = 16'h0000;

   // ****************************************
   // sequence
   // ****************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= S_IDLE;
         cnt_ff <= CNT_ZERO;
      end
      else
      begin
         unique case (state_ff)
            S_IDLE:
            begin
               cnt_ff <= CNT_ZERO;
               if (start)
                  state_ff <= S_K;
            end
            S_K:
            begin
               cnt_ff <= cnt_ff + 16'h0001;
               if (cnt_ff == K_LAST)
                  state_ff <= S_SE0;
            end
            S_SE0:
            begin
               cnt_ff <= CNT_ZERO;
               state_ff <= S_HS;
            end
            S_HS:
               state_ff <= S_WAIT;
            S_WAIT:
            begin
               cnt_ff <= cnt_ff + 16'h0001;
               if (cnt_ff == IDLE_LAST)
                  state_ff <= S_RUN;
            end
            S_RUN:
               state_ff <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lineDrive <= '{drive: 1'b0, state: uspsr_pkg::LS_J};
         bypass <= 1'b0;
         hsSwitch <= 1'b0;
         sofAllow <= 1'b0;
         busy <= 1'b0;
         evt <= '0;
      end
      else
      begin
         lineDrive.drive <= (state_ff == S_K) || (state_ff == S_SE0) || (state_ff == S_HS);
         lineDrive.state <= (state_ff == S_K) ? uspsr_pkg::LS_K : uspsr_pkg::LS_SE0;
         bypass <= (state_ff == S_K) || (state_ff == S_SE0);
         hsSwitch <= (state_ff == S_HS) || (state_ff == S_WAIT) || (state_ff == S_RUN);
         sofAllow <= (state_ff == S_RUN);
         busy <= (state_ff != S_IDLE);
         evt.resumeDone <= (state_ff == S_RUN);
         evt.hsDisconnect <= discEnable && hsLevelSeen && (state_ff == S_IDLE);
      end
   end
endmodule
`default_nettype wire

// >>> pkg/uspsr_pkg.sv
// package: register map, fields, timing and carrier types for the suspend/resume controller
`default_nettype none
package uspsr_pkg;
   // register byte offsets
   localparam logic [7:0] PORT_STATUS_CONTROL_REG = 8'h00;
   localparam logic [7:0] PHY_CONTROL_REG = 8'h04;
   localparam logic [7:0] PHY_POWER_DOWN_REG = 8'h08;
   localparam logic [7:0] IRQ_STATUS_REG = 8'h0c;
   localparam logic [7:0] IRQ_MASK_REG = 8'h10;
   localparam logic [7:0] LINE_STATE_REG = 8'h14;
   // port_status_control_reg fields
   localparam int PSC_HOST_ROLE = 0;
   localparam int PSC_RUN = 1;
   localparam int PSC_PORT_SUSPEND = 2;
   localparam int PSC_LOW_POWER = 3;
   localparam int PSC_FORCE_RESUME = 4;
   localparam int PSC_HIGH_SPEED = 5;
   // phy_control_reg fields
   localparam int PCR_DISC_EN = 0;
   localparam int PCR_CLK_GATE = 1;
   // irq bits
   localparam int IRQ_PORT_CHANGE = 0;
   localparam int IRQ_REMOTE_WAKE = 1;
   localparam int IRQ_HS_DISCONNECT = 2;
   localparam int IRQ_RESUME_DONE = 3;
   localparam int IRQ_W = 4;
   localparam int PWD_W = 8;
   localparam logic [PWD_W-1:0] PWD_ALL = 8'hff;
   localparam logic [PWD_W-1:0] PWD_NONE = 8'h00;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int RESUME_K_US = 20;
   localparam int SE0_IDLE_PS = 1_333_000;
   localparam int CLK_PS = 50_000;
   localparam int RESUME_K_CYC = RESUME_K_US * (CLK_HZ / 1_000_000);
   localparam int SE0_IDLE_CYC = (SE0_IDLE_PS + CLK_PS - 1) / CLK_PS;
   localparam int CNT_W = 16;
   // line states on the data pair
   typedef enum logic [1:0] {LS_SE0 = 2'h0, LS_J = 2'h1, LS_K = 2'h2, LS_SE1 = 2'h3} uspsr_line_t;
   // line drive bundle toward the transceiver
   typedef struct packed {
      logic drive;
      uspsr_line_t state;
   } uspsr_drive_t;
   // events reported by the resume sequencer
   typedef struct packed {
      logic resumeDone;
      logic hsDisconnect;
   } uspsr_seq_evt_t;
endpackage
`default_nettype wire

// >>> verification/testbench.sv
// testbench: apb register sequences against the suspend/resume controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam logic [7:0] PSC = uspsr_pkg::PORT_STATUS_CONTROL_REG;
   localparam logic [7:0] PCR = uspsr_pkg::PHY_CONTROL_REG;
   localparam logic [7:0] PWD = uspsr_pkg::PHY_POWER_DOWN_REG;
   localparam logic [7:0] STS = uspsr_pkg::IRQ_STATUS_REG;
   localparam logic [7:0] MSK = uspsr_pkg::IRQ_MASK_REG;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, hostResumeIn, remoteWakeIn, hsLevelIn, lineDriveEn, hsMode;
   logic sofEnable, lowPowerOut, clockGateOut, irq, discDetectOut, rerr;
   logic [31:0] rdv;
   logic wakeReq = 1'b0, resumeReq = 1'b0, slowDev = 1'b0;
   logic [1:0] lineStateIn, lineDriveState, ctrlLineState;
   logic [7:0] powerDownOut;
   int miscompares = 0, samplesChecked = 0;
   always #25 clk = ~clk;
   uspsr_ctrl i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .lineStateIn, .hostResumeIn, .remoteWakeIn, .hsLevelIn,
      .lineDriveEn, .lineDriveState, .ctrlLineState, .hsMode, .sofEnable, .lowPowerOut,
      .powerDownOut, .clockGateOut, .discDetectOut, .irq);
   uspsr_usb_peer i_peer (.clk, .rst_n, .lineDriveEn, .lineDriveState, .hsMode, .sofEnable,
      .wakeReq, .resumeReq, .slowDev, .lineStateIn, .hostResumeIn, .remoteWakeIn, .hsLevelIn);
   // ***********
   // tasks
   // ***********
   task close_out;
      if (miscompares == 0 && samplesChecked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      samplesChecked++;
      if (g !== x)
      begin
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
         miscompares++;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      repeat (2) @(posedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & m, x);
      chk(e, 32'h0);
   endtask
   task pulse(input logic w);
      @(posedge clk);
      wakeReq <= w;
      resumeReq <= !w;
      repeat (4) @(posedge clk);
      wakeReq <= 1'b0;
      resumeReq <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task resume(input logic [31:0] x);
      int n;
      wr(PSC, 32'h07);
      wr(PSC, 32'h17);
      n = 0;
      while (lineDriveEn !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      chk(lineDriveState, uspsr_pkg::LS_K);
      repeat (8) @(posedge clk);
      chk(ctrlLineState, uspsr_pkg::LS_K);
      n = 0;
      while (sofEnable !== 1'b1 && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      chk(hsMode, 32'h1);
      chk(32'(n < 1000), 32'h1);
      repeat (12) @(posedge clk);
      rd(STS, x, 32'hf);
      chk(irq, 32'h1);
      wr(STS, 32'hf);
      rd(STS, 32'h0, 32'hf);
   endtask
   // ***********
   // sequence
   // ***********
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(PSC, 32'h0, 32'hffffffff);
      rd(PWD, 32'h0, 32'hffffffff);
      apb(1'b0, 8'h18, 32'h0, rdv, rerr);
      chk(rdv, 32'h0);
      chk(rerr, 32'h1);
      wr(MSK, 32'h8);
      wr(PCR, 32'h0);
      resume(32'h8);
      slowDev <= 1'b1;
      resume(32'h8);
      wr(PCR, 32'h1);
      chk(discDetectOut, 32'h1);
      resume(32'hc);
      wr(PCR, 32'h0);
      slowDev <= 1'b0;
      wr(MSK, 32'h0);
      chk(irq, 32'h0);
      wr(PSC, 32'h02);
      wr(PSC, 32'h0a);
      chk(lowPowerOut, 32'h0);
      wr(PSC, 32'h06);
      pulse(1'b1);
      rd(STS, 32'h1, 32'h1);
      chk(lowPowerOut, 32'h0);
      wr(STS, 32'hf);
      wr(PSC, 32'h0e);
      chk(lowPowerOut, 32'h1);
      pulse(1'b1);
      rd(STS, 32'h2, 32'h2);
      wr(STS, 32'hf);
      wr(PSC, 32'h0e);
      wr(PWD, 32'hff);
      wr(PCR, 32'h2);
      chk(clockGateOut, 32'h1);
      pulse(1'b1);
      chk(powerDownOut, 32'h0);
      chk(clockGateOut, 32'h0);
      rd(PWD, 32'h0, 32'hff);
      wr(PSC, 32'h0e);
      pulse(1'b0);
      rd(PSC, 32'h0, 32'h8);
      wr(PSC, 32'h06);
      wr(PSC, 32'h0e);
      wr(PSC, 32'h06);
      wr(PSC, 32'h16);
      rd(PSC, 32'h2, 32'he);
      close_out;
   end
   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      close_out;
   end
endmodule
`default_nettype wire

// >>> verification/uspsr_monitor.sv
// checker: resume, idle and suspend-flag properties at the controller ports
`timescale 1ns/100ps
`default_nettype none
module uspsr_monitor
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   // link side
   input wire logic hostResumeIn,
   input wire logic remoteWakeIn,
   input wire logic lineDriveEn,
   input wire logic [1:0] lineDriveState,
   input wire logic hsMode,
   input wire logic sofEnable,
   input wire logic lowPowerOut,
   input wire logic [7:0] powerDownOut,
   input wire logic clockGateOut
);
   // ***********
   // helper logic
   // ***********
   logic [5:0] idleCnt_ff;
   logic kDrive;
   assign kDrive = lineDriveEn && lineDriveState == uspsr_pkg::LS_K;
   // cycles since the last driven K
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         idleCnt_ff <= 6'h00;
      else if (kDrive)
         idleCnt_ff <= 6'h00;
      else if (idleCnt_ff != 6'h3f)
         idleCnt_ff <= idleCnt_ff + 6'h01;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ***********
   // properties
   // ***********
   a_k_first: assert property ($rose(lineDriveEn) |-> kDrive)
      else $error("resume drive did not open with K");
   a_se0_end: assert property ($past(rst_n) && $past(kDrive) && !kDrive |->
      lineDriveEn && lineDriveState == uspsr_pkg::LS_SE0)
      else $error("K drive not followed by SE0");
   a_hs_switch: assert property (lineDriveEn && lineDriveState == uspsr_pkg::LS_SE0
      |-> ##[0:3] hsMode)
      else $error("no high speed switch after SE0");
   a_drive_stop: assert property ($rose(hsMode) |-> ##[0:2] !lineDriveEn)
      else $error("SE0 drive kept after speed switch");
   a_sof_soon: assert property ($rose(hsMode) |-> ##[1:60] sofEnable)
      else $error("frames never released after resume");
   a_sof_idle: assert property (sofEnable |-> !lineDriveEn &&
      idleCnt_ff >= uspsr_pkg::SE0_IDLE_CYC)
      else $error("frame released before idle time");
   a_host_resume: assert property ($rose(hostResumeIn) && lowPowerOut
      |-> ##[1:6] !lowPowerOut)
      else $error("host resume left low power set");
   a_lp_write_only: assert property ($rose(lowPowerOut) |->
      $past(psel && penable && pwrite && paddr == uspsr_pkg::PORT_STATUS_CONTROL_REG, 2))
      else $error("low power set without a register write");
   a_wake_clear: assert property ($rose(remoteWakeIn) && lowPowerOut |-> ##[1:6]
      (powerDownOut == 8'h00 && !clockGateOut && !lowPowerOut))
      else $error("wakeup left power-down or clock gate set");
endmodule
bind uspsr_ctrl uspsr_monitor i_mon (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
   .hostResumeIn, .remoteWakeIn, .lineDriveEn, .lineDriveState, .hsMode, .sofEnable,
   .lowPowerOut, .powerDownOut, .clockGateOut);
`default_nettype wire

// >>> verification/uspsr_usb_peer.sv
// partner: attached usb party on the data pair, wake and resume sources
`timescale 1ns/100ps
`default_nettype none
module uspsr_usb_peer
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // from the controller
   input wire logic lineDriveEn,
   input wire logic [1:0] lineDriveState,
   input wire logic hsMode,
   input wire logic sofEnable,
   // scenario commands
   input wire logic wakeReq,
   input wire logic resumeReq,
   input wire logic slowDev,
   // toward the controller
   output logic [1:0] lineStateIn,
   output logic hostResumeIn,
   output logic remoteWakeIn,
   output logic hsLevelIn
);
   logic [3:0] lvlCnt_ff;
   // released pair: pull-up gives J, high speed idle is SE0
   assign lineStateIn = lineDriveEn ? lineDriveState : (hsMode ? 2'h0 : 2'h1);
   assign hostResumeIn = resumeReq;
   assign remoteWakeIn = wakeReq;
   // slow device still full speed: frame shows disconnect level
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         lvlCnt_ff <= 4'h0;
      else if (sofEnable && slowDev)
         lvlCnt_ff <= 4'h8;
      else if (lvlCnt_ff != 4'h0)
         lvlCnt_ff <= lvlCnt_ff - 4'h1;
   end
   assign hsLevelIn = lvlCnt_ff != 4'h0;
endmodule
`default_nettype wire
